// ===== ledio_pkg.sv
// Package: constants and types for the latched event line bank
// Notes on behaviour
// RULE_01 - 48 lines as six 8-bit ports
// RULE_02 - Register block based at 0x120
// RULE_03 - Latched event sensing on lines 0..23
// RULE_04 - Software picks rising or falling edge
// RULE_05 - Strap routes interrupt: none, 15, 10, 5
// RULE_06 - Open enable strap runs bank, closed disables
// RULE_07 - Interrupt holds until software clears latch; the code also drops it when the line's mask bit is cleared
package ledio_pkg;
    localparam int LINES      = 48;
    localparam int PORTS      = 6;
    localparam int EV_LINES   = 24;
    // Byte base of the register block
    localparam logic [11:0] BASE_ADDR = 12'h120;
    // Word offsets from the base (byte address = base + offset)
    localparam logic [7:0] OFS_DATA_LO = 8'h00; // Lines 0..31
    localparam logic [7:0] OFS_DATA_HI = 8'h04; // Lines 32..47
    localparam logic [7:0] OFS_DIR_LO  = 8'h08; // Drive enable 0..31
    localparam logic [7:0] OFS_DIR_HI  = 8'h0C; // Drive enable 32..47
    localparam logic [7:0] OFS_POL     = 8'h10; // 1 = rising edge
    localparam logic [7:0] OFS_MASK    = 8'h14; // Event interrupt enables
    localparam logic [7:0] OFS_STATUS  = 8'h18; // Sticky, write 1 clear
    localparam logic [7:0] OFS_INFO    = 8'h1C; // Straps and irq level
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Interrupt route strap codes
    localparam logic [1:0] ROUTE_NONE  = 2'h0;
    localparam logic [1:0] ROUTE_IRQ15 = 2'h1;
    localparam logic [1:0] ROUTE_IRQ10 = 2'h2;
    localparam logic [1:0] ROUTE_IRQ5  = 2'h3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Host interrupt request lines driven by the bank
    typedef struct packed {
        logic irq15;
        logic irq10;
        logic irq5;
    } ledio_irq_type;
endpackage

// ===== ledio_sync.sv
// Two-stage synchroniser for a vector of pins
`timescale 1ns/1ps
`default_nettype none
module ledio_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Data
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // Two flops, first read only by the second
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// ===== ledio_top.sv
// Latched event digital line bank with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module ledio_top (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Board straps (pins)
    input  wire logic                   bank_disable_strap,
    input  wire logic [1:0]             irq_route_strap,
    // Line bank pins
    input  wire logic [47:0]            line_in,
    output var  logic [47:0]            line_out,
    output var  logic [47:0]            line_oe,
    // Host interrupt lines
    output var  ledio_pkg::ledio_irq_type irq_out
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [47:0] line_s;
    logic [2:0]  strap_s;

    ledio_sync #(.W(48)) u_line_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (line_in),
        .sync_out (line_s)
    );

    ledio_sync #(.W(3)) u_strap_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({bank_disable_strap, irq_route_strap}),
        .sync_out (strap_s)
    );

    ////////////////////////////////////////////////////////////////////
    // State
    logic [47:0] out_reg;
    logic [47:0] dir_reg;
    logic [23:0] pol_reg;
    logic [23:0] mask_reg;
    logic [23:0] status;
    logic [23:0] prev_line;
    logic        bank_on;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [47:0] next_out_reg;
    logic [47:0] next_dir_reg;
    logic [23:0] next_pol_reg;
    logic [23:0] next_mask_reg;
    logic [23:0] next_status;
    logic [23:0] next_prev_line;
    logic        next_bank_on;
    logic        next_aw_held;
    logic        next_w_held;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [47:0] next_line_out;
    logic [47:0] next_line_oe;
    ledio_pkg::ledio_irq_type next_irq;

    // Byte-lane merge of write data into a register word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    // Decode: block-relative offset for word-aligned addresses inside the block, else 8'hFF
    function automatic logic [7:0] decode(input logic [11:0] a);
        logic [11:0] d;
        d = a - ledio_pkg::BASE_ADDR;                         // [RULE_02]
        if (a >= ledio_pkg::BASE_ADDR && d < 12'h020 && d[1:0] == 2'h0)
            return d[7:0];
        return 8'hFF;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Per-line edge detection for the event-capable lines
    logic [23:0] edge_hit;

    genvar gi;
    generate
        for (gi = 0; gi < ledio_pkg::EV_LINES; gi++)
        begin : g_ev
            // Polarity 1 selects rising, 0 selects falling      [RULE_04]
            assign edge_hit[gi] = bank_on &&
                (pol_reg[gi] ? (line_s[gi] && !prev_line[gi])
                             : (!line_s[gi] && prev_line[gi]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Next-state logic: registers, bus, events, pins
    always_comb
    begin
        logic       do_wr;
        logic       do_rd;
        logic [7:0] wofs;
        logic [7:0] rofs;
        logic [31:0] rd;
        logic       pend;
        do_wr = 1'b0;
        do_rd = 1'b0;
        wofs  = 8'hFF;
        rofs  = 8'hFF;
        rd    = ledio_pkg::RST_ZERO;
        pend  = 1'b0;

        next_out_reg   = out_reg;
        next_dir_reg   = dir_reg;
        next_pol_reg   = pol_reg;
        next_mask_reg  = mask_reg;
        next_prev_line = line_s[23:0];
        next_bank_on   = !strap_s[2];                          // [RULE_06]
        next_aw_held   = aw_held;
        next_w_held    = w_held;
        next_aw_addr   = aw_addr;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = s_axi_bvalid;
        next_bresp     = s_axi_bresp;
        next_rvalid    = s_axi_rvalid;
        next_rdata     = s_axi_rdata;
        next_rresp     = s_axi_rresp;

        // Capture address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;

        // Perform the write once both halves are held
        if (aw_held && w_held && !s_axi_bvalid)
        begin
            do_wr        = 1'b1;
            wofs         = decode(aw_addr);
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wofs == 8'hFF) ? ledio_pkg::RESP_SLVERR
                                           : ledio_pkg::RESP_OKAY;
        end

        // Register writes
        if (do_wr)
        begin
            case (wofs)
                ledio_pkg::OFS_DATA_LO:
                    next_out_reg[31:0] = merge(out_reg[31:0], w_data, w_strb);
                ledio_pkg::OFS_DATA_HI:
                    next_out_reg[47:32] = 16'(merge({16'h0000, out_reg[47:32]},
                                                    w_data, w_strb));
                ledio_pkg::OFS_DIR_LO:
                    next_dir_reg[31:0] = merge(dir_reg[31:0], w_data, w_strb);
                ledio_pkg::OFS_DIR_HI:
                    next_dir_reg[47:32] = 16'(merge({16'h0000, dir_reg[47:32]},
                                                    w_data, w_strb));
                ledio_pkg::OFS_POL:
                    next_pol_reg = 24'(merge({8'h00, pol_reg}, w_data, w_strb));
                ledio_pkg::OFS_MASK:
                    next_mask_reg = 24'(merge({8'h00, mask_reg}, w_data,
                                              w_strb));
                default:
                    ;
            endcase
        end

        // Sticky event latches: set wins over write-one clear   [RULE_03]
        next_status = status;
        if (do_wr && wofs == ledio_pkg::OFS_STATUS)
            next_status = status & ~(24'(merge(ledio_pkg::RST_ZERO, w_data,
                                               w_strb)));          // [RULE_07]
        next_status = next_status | edge_hit;                      // [RULE_03]

        // Read channel
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            do_rd = 1'b1;
            rofs  = decode(s_axi_araddr);
        end
        pend = |(status & mask_reg);
        if (do_rd)
        begin
            case (rofs)
                ledio_pkg::OFS_DATA_LO: rd = line_s[31:0];         // [RULE_01]
                ledio_pkg::OFS_DATA_HI: rd = {16'h0000, line_s[47:32]};
                ledio_pkg::OFS_DIR_LO:  rd = dir_reg[31:0];
                ledio_pkg::OFS_DIR_HI:  rd = {16'h0000, dir_reg[47:32]};
                ledio_pkg::OFS_POL:     rd = {8'h00, pol_reg};
                ledio_pkg::OFS_MASK:    rd = {8'h00, mask_reg};
                ledio_pkg::OFS_STATUS:  rd = {8'h00, status};
                ledio_pkg::OFS_INFO:
                    rd = {28'h0000000, pend, bank_on, strap_s[1:0]};
                default:                rd = ledio_pkg::RST_ZERO;
            endcase
            next_rvalid = 1'b1;
            next_rdata  = rd;
            next_rresp  = (rofs == 8'hFF) ? ledio_pkg::RESP_SLVERR
                                          : ledio_pkg::RESP_OKAY;
        end

        // Ready only when a new item can be held
        next_awready = !next_aw_held && !s_axi_awready;
        next_wready  = !next_w_held && !s_axi_wready;
        next_arready = !next_rvalid && !s_axi_arready;

        // Pins: a disabled bank drives nothing                  [RULE_06]
        next_line_out = out_reg;
        next_line_oe  = bank_on ? dir_reg : 48'h000000000000;

        // Interrupt routed to at most one host line, none for ROUTE_NONE       [RULE_05] [RULE_07]
        next_irq = '0;
        case (strap_s[1:0])
            ledio_pkg::ROUTE_IRQ15: next_irq.irq15 = pend;
            ledio_pkg::ROUTE_IRQ10: next_irq.irq10 = pend;
            ledio_pkg::ROUTE_IRQ5:  next_irq.irq5  = pend;
            default:                next_irq       = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_reg       <= 48'h000000000000;
            dir_reg       <= 48'h000000000000;
            pol_reg       <= 24'h000000;
            mask_reg      <= 24'h000000;
            status        <= 24'h000000;
            prev_line     <= 24'h000000;
            bank_on       <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
            line_out      <= 48'h000000000000;
            line_oe       <= 48'h000000000000;
            irq_out       <= '0;
        end
        else
        begin
            out_reg       <= next_out_reg;
            dir_reg       <= next_dir_reg;
            pol_reg       <= next_pol_reg;
            mask_reg      <= next_mask_reg;
            status        <= next_status;
            prev_line     <= next_prev_line;
            bank_on       <= next_bank_on;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            line_out      <= next_line_out;
            line_oe       <= next_line_oe;
            irq_out       <= next_irq;
        end
    end
endmodule
`default_nettype wire

// ===== ledio_monitor.sv
// Checker of bus, strap and interrupt timing for the line bank
`timescale 1ns/1ps
`default_nettype none
module ledio_monitor (
    // Clock and reset
    input wire logic                     aclk,
    input wire logic                     aresetn,
    // Register bus
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic [1:0]               s_axi_bresp,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic [11:0]              s_axi_araddr,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [31:0]              s_axi_rdata,
    input wire logic [1:0]               s_axi_rresp,
    input wire logic                     s_axi_rvalid,
    input wire logic                     s_axi_rready,
    // Straps and pins
    input wire logic                     bank_disable_strap,
    input wire logic [1:0]               irq_route_strap,
    input wire logic [47:0]              line_oe,
    input wire ledio_pkg::ledio_irq_type irq_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // Bus answers
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr < 12'h120 || s_axi_araddr > 12'h13F ||
        s_axi_araddr[1:0] != 2'h0) |=> s_axi_rdata == 32'h0 &&
        s_axi_rresp == ledio_pkg::RESP_SLVERR) else $error("bad read");

    ////////////////////////////////////////////////////////////////////////
    // Straps and interrupt lines
    a_bank_off: assert property (bank_disable_strap [*5]
        |-> line_oe == 48'h0) else $error("disabled bank drives");
    a_route_none: assert property
        ((irq_route_strap == ledio_pkg::ROUTE_NONE) [*5] |-> irq_out == 3'h0)
        else $error("irq on route none");
    a_one_line: assert property ($countones(irq_out) <= 1)
        else $error("several irq lines");
    a_irq_kept: assert property ((|irq_out && !s_axi_awvalid &&
        $stable(irq_route_strap) && $stable(bank_disable_strap)) [*5]
        |=> |irq_out) else $error("irq fell without clear");
endmodule

bind ledio_top ledio_monitor i_mon (.*);
`default_nettype wire

// ===== ledio_field.sv
// Field side model: rack signals meeting the bank's line drivers
`timescale 1ns/1ps
`default_nettype none
module ledio_field (
    // From the bank
    input  wire logic [47:0] line_out,
    input  wire logic [47:0] line_oe,
    // Level the rack puts on undriven lines
    input  wire logic [47:0] field_level,
    // To the bank
    output var  logic [47:0] line_in
);
    // Driven lines read back the bank, others show the rack level
    always_comb
        for (int i = 0; i < 48; i++)
            line_in[i] = line_oe[i] ? line_out[i] : field_level[i];
endmodule
`default_nettype wire

// ===== ledio_top_bench.sv
// Self-checking bench for the latched event line bank
`timescale 1ns/1ps
`default_nettype none
module ledio_top_bench;
    logic                     aclk, aresetn, bank_disable_strap;
    logic [11:0]              s_axi_awaddr, s_axi_araddr;
    logic [31:0]              s_axi_wdata, s_axi_rdata;
    logic [3:0]               s_axi_wstrb;
    logic [1:0]               s_axi_bresp, s_axi_rresp, irq_route_strap;
    logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                     s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                     s_axi_arvalid, s_axi_arready;
    logic                     s_axi_rvalid, s_axi_rready;
    logic [47:0]              line_in, line_out, line_oe, field_level;
    ledio_pkg::ledio_irq_type irq_out;
    logic [33:0]              exp_r [$];
    logic [1:0]               exp_b [$];
    int                       n_fail, checked;

    ledio_top i_dut (.*);
    ledio_field i_field (.*);

    ////////////////////////////////////////////////////////////////////////
    // Compare, closing report and bounded wait
    task automatic cmp(input logic [47:0] e, input logic [47:0] g);
        checked++;
        if (e !== g)
        begin
            $display("ERROR at %0t: expected %h got %h", $time, e, g);
            n_fail++;
        end
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 200)
        begin
            n_fail++;
            results();
        end
    endtask
    function automatic logic [11:0] ad(input logic [7:0] o);
        return ledio_pkg::BASE_ADDR + {4'h0, o};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus master tasks, expected answers noted in queues
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r = ledio_pkg::RESP_OKAY,
                      input logic [3:0] s = 4'hF);
        int   n;
        logic aw, w;
        n = 0;
        aw = 1'h1;
        w = 1'h1;
        exp_b.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        while (aw || w)
        begin
            tick(n);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid  <= w;
        end
        repeat ($urandom_range(2)) @(posedge aclk);
        s_axi_bready <= 1'h1;
        do
            tick(n);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        int   n;
        logic ar;
        n = 0;
        ar = 1'h1;
        exp_r.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        while (ar)
        begin
            tick(n);
            ar = !s_axi_arready;
            s_axi_arvalid <= ar;
        end
        repeat ($urandom_range(2)) @(posedge aclk);
        s_axi_rready <= 1'h1;
        do
            tick(n);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    // Watcher takes the oldest note at each answer
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            cmp(48'(exp_r.pop_front()),
                48'({s_axi_rresp, s_axi_rdata}));
        if (s_axi_bvalid && s_axi_bready)
            cmp(48'(exp_b.pop_front()), 48'(s_axi_bresp));
    end

    // Clock
    initial
    begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [47:0] b, p, x, q;
        n_fail = 0;
        checked = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, bank_disable_strap} = '0;
        s_axi_wstrb = 4'hF;
        field_level = '0;
        irq_route_strap = ledio_pkg::ROUTE_IRQ10;
        aresetn = 1'h0;
        q = {16'($urandom(32'hF2E3F832)), $urandom};
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        rd(ad(ledio_pkg::OFS_POL), 34'h0);
        rd(ad(ledio_pkg::OFS_STATUS), 34'h0);
        rd(ad(ledio_pkg::OFS_INFO), 34'h6);
        $display("test reset values done");
        // Drive all lines, read lines 0..31 back from the bank's drive, then lines 32..47 from the rack
        wr(ad(ledio_pkg::OFS_DIR_LO), 32'hFFFFFFFF);
        wr(ad(ledio_pkg::OFS_DIR_HI), 32'h0000FFFF);
        wr(ad(ledio_pkg::OFS_DATA_LO), q[31:0]);
        wr(ad(ledio_pkg::OFS_DATA_HI), {16'h0, q[47:32]});
        cmp(q, line_out);
        cmp(48'hFFFFFFFFFFFF, line_oe);
        rd(ad(ledio_pkg::OFS_DATA_LO), {2'h0, q[31:0]});
        wr(ad(ledio_pkg::OFS_DIR_LO), 32'h0);
        wr(ad(ledio_pkg::OFS_DIR_HI), 32'h0);
        b = {16'($urandom), $urandom};
        p = {16'($urandom), $urandom};
        p[0] = ~b[0];
        field_level <= b;
        repeat (8) @(posedge aclk);
        rd(ad(ledio_pkg::OFS_DATA_HI), {18'h0, b[47:32]});
        $display("test line ports done");
        // Events in both directions, sticky, masked and cleared
        wr(ad(ledio_pkg::OFS_POL), p[31:0]);
        wr(ad(ledio_pkg::OFS_MASK), 32'hFFFFFF);
        wr(ad(ledio_pkg::OFS_STATUS), 32'hFFFFFF);
        rd(ad(ledio_pkg::OFS_STATUS), 34'h0);
        field_level <= ~b;
        repeat (8) @(posedge aclk);
        x = (b ^ p) & 48'hFFFFFF;
        rd(ad(ledio_pkg::OFS_STATUS), {2'h0, x[31:0]});
        rd(ad(ledio_pkg::OFS_INFO), 34'hE);
        cmp(48'h2, 48'(irq_out));
        irq_route_strap <= ledio_pkg::ROUTE_IRQ15;
        repeat (6) @(posedge aclk);
        cmp(48'h4, 48'(irq_out));
        irq_route_strap <= ledio_pkg::ROUTE_IRQ5;
        repeat (6) @(posedge aclk);
        cmp(48'h1, 48'(irq_out));
        irq_route_strap <= ledio_pkg::ROUTE_NONE;
        repeat (6) @(posedge aclk);
        cmp(48'h0, 48'(irq_out));
        irq_route_strap <= ledio_pkg::ROUTE_IRQ10;
        wr(ad(ledio_pkg::OFS_MASK), 32'h0);
        cmp(48'h0, 48'(irq_out));
        field_level <= b;
        repeat (8) @(posedge aclk);
        rd(ad(ledio_pkg::OFS_STATUS), 34'hFFFFFF);
        wr(ad(ledio_pkg::OFS_MASK), 32'hFFFFFF);
        cmp(48'h2, 48'(irq_out));
        wr(ad(ledio_pkg::OFS_STATUS), x[31:0]);
        rd(ad(ledio_pkg::OFS_STATUS), {10'h0, ~x[23:0]});
        wr(ad(ledio_pkg::OFS_STATUS), 32'hFFFFFF);
        cmp(48'h0, 48'(irq_out));
        $display("test events done");
        // Closed strap stops driving and event capture
        // Only byte lane 1 of the upper drive word is written
        wr(ad(ledio_pkg::OFS_DIR_HI), 32'hFFFF,
           ledio_pkg::RESP_OKAY, 4'h2);
        cmp(48'hFF0000000000, line_oe);
        bank_disable_strap <= 1'h1;
        // Lines move only once the closed strap has taken effect
        repeat (4) @(posedge aclk);
        field_level <= ~b;
        repeat (8) @(posedge aclk);
        cmp(48'h0, line_oe);
        rd(ad(ledio_pkg::OFS_INFO), 34'h2);
        rd(ad(ledio_pkg::OFS_STATUS), 34'h0);
        bank_disable_strap <= 1'h0;
        $display("test bank disable done");
        // Addresses outside the block or not word-aligned are refused
        rd(12'h11C, {ledio_pkg::RESP_SLVERR, 32'h0});
        rd(12'h140, {ledio_pkg::RESP_SLVERR, 32'h0});
        wr(12'h140, 32'h0, ledio_pkg::RESP_SLVERR);
        wr(12'h122, 32'h0, ledio_pkg::RESP_SLVERR);
        cmp(q, line_out);
        $display("test decode done");
        results();
    end
endmodule
`default_nettype wire
